// ---- core/capture_compare_timer.sv ----
/*
  16-bit capture/compare timer with prescaler, four capture channels, three
  compare channels driving an 8-bit output port, and a shared overflow request.
  assumes one ahb-lite master, word transfers only, hclk is the oscillator.
*/
// Chosen here: register access over AHB-Lite.
// Operation
// - counter steps once per prescaler output; prescaler divides by 1, 2, 4 or 8
// - source field: halt, oscillator/12, reserved test (halted), external count pin
// - prescaler steps on rising input edge; external clock at most oscillator/12
// - prescaler clears on divider or source change and on counter reset
// - counter bytes read live; software writes never change the counter
// - counter clears at reset and on clear-pin rising edge when enabled
// - idle mode holds counter and prescaler cleared and stopped
// - selected capture edge copies counter into capture register and sets flag
// - per input, odd bit selects falling, even bit rising; none disables
// - compare registers always compared with counter; match sets its flag
// - compare 0 sets enabled port bits 0-5, compare 1 clears enabled bits
// - simultaneous compare 0 and 1 match clears bits, never sets them
// - compare 2 toggles enabled bits 6,7 according to their toggle state
// - set-enable bits 6 and 7 are read-only toggle state
// - compare registers reset to zero
// - software port access does not disturb match-driven port actions
// - byte and full overflow set their flags; control bits 6,7 gate request
// - flag register: overflow bit 7, compare 6-4, capture 3-0
// - hardware only sets flags; software clears them
`default_nettype none
module capture_compare_timer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        ext_count_pin,
  input  wire logic        ext_counter_clear_pin,
  input  wire logic        capture_input_0,
  input  wire logic        capture_input_1,
  input  wire logic        capture_input_2,
  input  wire logic        capture_input_3,
  input  wire logic        idle_mode,
  output logic [7:0]       compare_output_port,
  output logic             overflow_irq
);

  cct_pkg::state_s st_r;
  cct_pkg::state_s st_nxt;

  logic [3:0] cap_pin;
  logic       tick12;
  logic       ext_rise;
  logic       clr_rise;
  logic       src_tick;
  logic       cfg_chg;
  logic       clr_cnt;
  logic [2:0] psc_last;
  logic       advance;
  logic [3:0] cap_evt;
  logic [2:0] match;
  logic       addr_ph;
  logic       flag_wr;
  logic       port_wr;
  logic       ctl_wr;
  logic       cnt_wr;

  assign cap_pin  = {capture_input_3, capture_input_2, capture_input_1, capture_input_0};
  assign tick12   = (st_r.div12 == cct_pkg::OSC_DIV_LAST);
  // second and third stages only; first stage feeds nothing else
  assign ext_rise = st_r.cnt_sync[1] & ~st_r.cnt_sync[2];
  assign clr_rise = st_r.clr_sync[1] & ~st_r.clr_sync[2];

  always_comb begin
    src_tick = 1'b0;
    unique case (st_r.ctl[1:0])
      cct_pkg::SRC_HALT: src_tick = 1'b0;
      cct_pkg::SRC_OSC:  src_tick = tick12;
      cct_pkg::SRC_TEST: src_tick = 1'b0;
      cct_pkg::SRC_PIN:  src_tick = ext_rise;
    endcase
  end

  always_comb begin
    psc_last = cct_pkg::PSC_DIV1;
    unique case (st_r.ctl[3:2])
      2'b00: psc_last = cct_pkg::PSC_DIV1;
      2'b01: psc_last = cct_pkg::PSC_DIV2;
      2'b10: psc_last = cct_pkg::PSC_DIV4;
      2'b11: psc_last = cct_pkg::PSC_DIV8;
    endcase
  end

  assign cfg_chg = (st_r.ctl[3:0] != st_r.cfg_prev);
  assign clr_cnt = idle_mode | (st_r.ctl[cct_pkg::CTL_EXT_CLR_EN] & clr_rise);
  assign advance = ~clr_cnt & ~cfg_chg & src_tick & (st_r.psc == psc_last);

  genvar gi;
  generate
    for (gi = 0; gi < cct_pkg::NUM_CAP; gi++) begin : g_cap
      // even bit rising, odd bit falling
      assign cap_evt[gi] =
        (st_r.edge_sel[2*gi]   &  st_r.cap_sync[gi][1] & ~st_r.cap_sync[gi][2]) |
        (st_r.edge_sel[2*gi+1] & ~st_r.cap_sync[gi][1] &  st_r.cap_sync[gi][2]);
    end
    for (gi = 0; gi < cct_pkg::NUM_CMP; gi++) begin : g_cmp
      // one event per counter value that equals the compare register
      assign match[gi] = st_r.cnt_new & (st_r.cnt == st_r.cmp[gi]);
    end
  endgenerate

  assign addr_ph = hsel & htrans[1] & hready;
  assign flag_wr = st_r.wr_pend & (st_r.idx == cct_pkg::IDX_FLAGS);
  assign port_wr = st_r.wr_pend & (st_r.idx == cct_pkg::IDX_PORT);
  assign ctl_wr  = st_r.wr_pend & (st_r.idx == cct_pkg::IDX_CTRL);
  assign cnt_wr  = st_r.wr_pend &
                   ((st_r.idx == cct_pkg::IDX_CNT_LO) | (st_r.idx == cct_pkg::IDX_CNT_HI));

  function automatic logic [31:0] read_word(input cct_pkg::state_s s, input logic [10:0] ix);
    logic [31:0] w;
    w = cct_pkg::RD_ZERO;
    if (ix == cct_pkg::IDX_FLAGS) begin
      w[7:0] = s.flags;
    end else if (ix == cct_pkg::IDX_CTRL) begin
      w[7:0] = s.ctl;
    end else if (ix == cct_pkg::IDX_EDGE) begin
      w[7:0] = s.edge_sel;
    end else if (ix == cct_pkg::IDX_STE) begin
      w[7:0] = {s.tgl, s.ste_lo};
    end else if (ix == cct_pkg::IDX_RTE) begin
      w[7:0] = s.port_reset_toggle_enable;
    end else if (ix == cct_pkg::IDX_CNT_LO) begin
      w[7:0] = s.cnt[7:0];
    end else if (ix == cct_pkg::IDX_CNT_HI) begin
      w[7:0] = s.cnt[15:8];
    end else if (ix == cct_pkg::IDX_PORT) begin
      w[7:0] = s.port;
    end else begin
      for (int k = 0; k < cct_pkg::NUM_CAP; k++) begin
        if (ix == cct_pkg::IDX_CAP0 + 11'(k)) begin
          w[15:0] = s.cap[k];
        end
      end
      for (int k = 0; k < cct_pkg::NUM_CMP; k++) begin
        if (ix == cct_pkg::IDX_CMP0 + 11'(k)) begin
          w[15:0] = s.cmp[k];
        end
      end
    end
    return w;
  endfunction : read_word

  always_comb begin
    st_nxt = st_r;

    // pin synchronisers
    st_nxt.cnt_sync = {st_r.cnt_sync[1:0], ext_count_pin};
    st_nxt.clr_sync = {st_r.clr_sync[1:0], ext_counter_clear_pin};
    for (int k = 0; k < cct_pkg::NUM_CAP; k++) begin
      st_nxt.cap_sync[k] = {st_r.cap_sync[k][1:0], cap_pin[k]};
    end

    // oscillator / 12 machine-cycle divider
    st_nxt.div12 = tick12 ? 4'h0 : st_r.div12 + 4'h1;
    st_nxt.cfg_prev = st_r.ctl[3:0];

    // data phase of a write; counter and capture registers ignore writes
    if (st_r.wr_pend) begin
      if (st_r.idx == cct_pkg::IDX_FLAGS) begin
        st_nxt.flags = hwdata[7:0];
      end else if (st_r.idx == cct_pkg::IDX_CTRL) begin
        st_nxt.ctl = hwdata[7:0];
      end else if (st_r.idx == cct_pkg::IDX_EDGE) begin
        st_nxt.edge_sel = hwdata[7:0];
      end else if (st_r.idx == cct_pkg::IDX_STE) begin
        st_nxt.ste_lo = hwdata[5:0];
      end else if (st_r.idx == cct_pkg::IDX_RTE) begin
        st_nxt.port_reset_toggle_enable = hwdata[7:0];
      end else if (st_r.idx == cct_pkg::IDX_PORT) begin
        st_nxt.port = hwdata[7:0];
      end else begin
        for (int k = 0; k < cct_pkg::NUM_CMP; k++) begin
          if (st_r.idx == cct_pkg::IDX_CMP0 + 11'(k)) begin
            st_nxt.cmp[k] = hwdata[15:0];
          end
        end
      end
    end

    // counter and prescaler
    st_nxt.cnt_new = 1'b0;
    if (clr_cnt) begin
      st_nxt.cnt     = 16'h0000;
      st_nxt.psc     = 3'h0;
      st_nxt.cnt_new = (st_r.cnt != 16'h0000);
    end else if (cfg_chg) begin
      st_nxt.psc = 3'h0;
    end else if (src_tick) begin
      if (advance) begin
        st_nxt.psc     = 3'h0;
        st_nxt.cnt     = st_r.cnt + 16'h0001;
        st_nxt.cnt_new = 1'b1;
      end else begin
        st_nxt.psc = st_r.psc + 3'h1;
      end
    end

    // hardware flag sets win over a software write in the same cycle
    if (advance && st_r.cnt[7:0] == cct_pkg::BYTE_MAX) begin
      st_nxt.ctl[cct_pkg::CTL_BYTE_OVF] = 1'b1;
    end
    if (advance && st_r.cnt == cct_pkg::CNT_MAX) begin
      st_nxt.flags[cct_pkg::FLG_FULL_OVF] = 1'b1;
    end
    for (int k = 0; k < cct_pkg::NUM_CAP; k++) begin
      if (cap_evt[k]) begin
        st_nxt.cap[k] = st_r.cnt;
        st_nxt.flags[cct_pkg::FLG_CAP0 + k] = 1'b1;
      end
    end
    for (int k = 0; k < cct_pkg::NUM_CMP; k++) begin
      if (match[k]) begin
        st_nxt.flags[cct_pkg::FLG_CMP0 + k] = 1'b1;
      end
    end

    // match actions on top of any software port write
    if (match[0] && !match[1]) begin
      st_nxt.port[5:0] = st_nxt.port[5:0] | st_r.ste_lo;
    end
    if (match[1]) begin
      st_nxt.port[5:0] = st_nxt.port[5:0] & ~st_r.port_reset_toggle_enable[5:0];
    end
    if (match[2]) begin
      for (int k = 0; k < 2; k++) begin
        if (st_r.port_reset_toggle_enable[cct_pkg::TGL_BIT_LO + k]) begin
          st_nxt.port[cct_pkg::TGL_BIT_LO + k] = ~st_r.tgl[k];
          st_nxt.tgl[k] = ~st_r.tgl[k];
        end
      end
    end

    // address phase; reads answer in the following data phase
    st_nxt.wr_pend = 1'b0;
    st_nxt.ready   = 1'b1;
    if (addr_ph) begin
      st_nxt.wr_pend = hwrite;
      st_nxt.idx     = haddr[12:2];
      if (!hwrite) begin
        st_nxt.rdata = read_word(st_r, haddr[12:2]);
      end
    end

    st_nxt.irq = (st_nxt.ctl[cct_pkg::CTL_BYTE_OVF] & st_nxt.ctl[cct_pkg::CTL_BYTE_IRQ_SEL]) |
                 (st_nxt.flags[cct_pkg::FLG_FULL_OVF] &
                  st_nxt.ctl[cct_pkg::CTL_FULL_IRQ_SEL]);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r       <= '0;
      st_r.ready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout           = st_r.ready;
  assign hresp               = 1'b0;
  assign hrdata              = st_r.rdata;
  assign compare_output_port = st_r.port;
  assign overflow_irq        = st_r.irq;

  localparam int TICK_GAP = cct_pkg::OSC_DIV;

  div_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tick12 |-> ##TICK_GAP tick12) else $error("osc divider period wrong");

  div_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tick12 |=> !tick12 [*8]) else $error("osc divider ticks early");

  halt_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.ctl[1:0] == cct_pkg::SRC_HALT) |=>
      (st_r.cnt == $past(st_r.cnt)) || (st_r.cnt == 16'h0000))
    else $error("counter moved while halted");

  idle_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    idle_mode |=> (st_r.cnt == 16'h0000) && (st_r.psc == 3'h0)) else $error("idle did not clear");

  psc_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_chg |=> st_r.psc == 3'h0) else $error("prescaler kept on change");

  cnt_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cnt_wr && !clr_cnt && !advance |=> st_r.cnt == $past(st_r.cnt))
    else $error("counter written");

  cap_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_evt[0] |=> (st_r.cap[0] == $past(st_r.cnt)) && st_r.flags[cct_pkg::FLG_CAP0])
    else $error("capture not taken");

  flag_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.flags[cct_pkg::FLG_CMP0] && !flag_wr |=> st_r.flags[cct_pkg::FLG_CMP0])
    else $error("flag cleared by hardware");

  set_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
    match[0] && !match[1] && !port_wr |=>
      st_r.port[5:0] == ($past(st_r.port[5:0]) | $past(st_r.ste_lo)))
    else $error("set match wrong");

  both_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
    match[0] && match[1] |=> (st_r.port[5:0] & $past(st_r.port_reset_toggle_enable[5:0])) == 6'h00)
    else $error("double match did not clear");

  toggle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    match[2] && st_r.port_reset_toggle_enable[cct_pkg::TGL_BIT_LO] |=>
      st_r.port[cct_pkg::TGL_BIT_LO] == !$past(st_r.tgl[0]))
    else $error("toggle wrong");

  byte_ovf_a: assert property (@(posedge hclk) disable iff (!hresetn)
    advance && st_r.cnt[7:0] == cct_pkg::BYTE_MAX |=> st_r.ctl[cct_pkg::CTL_BYTE_OVF])
    else $error("byte overflow flag missing");

  // counter stepping and clearing, capture gating, compare flags and port actions
  step_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
    advance |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
    else $error("counter did not step by one");

  ext_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clr_cnt |=> st_r.cnt == 16'h0000)
    else $error("counter not cleared");

  no_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.edge_sel[1:0] == 2'b00 |=> st_r.cap[0] == $past(st_r.cap[0]))
    else $error("capture without selected edge");

  cmp_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    match[1] |=> st_r.flags[cct_pkg::FLG_CMP0 + 1])
    else $error("compare flag missing");

  clear_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
    match[1] && !port_wr |=> (st_r.port[5:0] & $past(st_r.port_reset_toggle_enable[5:0])) == 6'h00)
    else $error("clear match wrong");

  tgl_state_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !match[2] |=> st_r.tgl == $past(st_r.tgl))
    else $error("toggle state moved without match");

  port_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    port_wr && (match == 3'b000) |=> st_r.port == $past(hwdata[7:0]))
    else $error("port write lost");

  cap_seen_c:  cover property (@(posedge hclk) disable iff (!hresetn) cap_evt[0]);
  full_ovf_c:  cover property (@(posedge hclk) disable iff (!hresetn)
    advance && st_r.cnt == cct_pkg::CNT_MAX);
  both_c:      cover property (@(posedge hclk) disable iff (!hresetn) match[0] && match[1]);
  toggle_c:    cover property (@(posedge hclk) disable iff (!hresetn)
    match[2] && st_r.port_reset_toggle_enable[cct_pkg::TGL_BIT_LO]);
  ext_clr_c:   cover property (@(posedge hclk) disable iff (!hresetn)
    clr_rise && st_r.ctl[cct_pkg::CTL_EXT_CLR_EN]);

endmodule : capture_compare_timer
`default_nettype wire

// ---- core/cct_pkg.sv ----
/*
  constants, register indices, field positions and the state record of the
  capture/compare timer. assumes a single 32-bit ahb-lite slave port.
*/
`default_nettype none
package cct_pkg;

  // register indices; byte address is four times the index
  localparam logic [10:0] IDX_FLAGS   = 11'h00c8;
  localparam logic [10:0] IDX_CTRL    = 11'h00ea;
  localparam logic [10:0] IDX_EDGE    = 11'h00eb;
  localparam logic [10:0] IDX_STE     = 11'h00ee;
  localparam logic [10:0] IDX_RTE     = 11'h00ef;
  localparam logic [10:0] IDX_CNT_LO  = 11'h0100;
  localparam logic [10:0] IDX_CNT_HI  = 11'h0101;
  localparam logic [10:0] IDX_CAP0    = 11'h0102;
  localparam logic [10:0] IDX_CMP0    = 11'h0106;
  localparam logic [10:0] IDX_PORT    = 11'h0109;
  localparam int          NUM_CAP     = 4;
  localparam int          NUM_CMP     = 3;

  // counter_control fields
  localparam int CTL_FULL_IRQ_SEL = 7;
  localparam int CTL_BYTE_IRQ_SEL = 6;
  localparam int CTL_EXT_CLR_EN   = 5;
  localparam int CTL_BYTE_OVF     = 4;

  // timer_interrupt_flags fields
  localparam int FLG_FULL_OVF     = 7;
  localparam int FLG_CMP0         = 4;
  localparam int FLG_CAP0         = 0;

  // set-enable / toggle field split
  localparam int PORT_SET_BITS    = 6;
  localparam int TGL_BIT_LO       = 6;

  // timing
  localparam logic [3:0] OSC_DIV_LAST = 4'hb;
  localparam int         OSC_DIV      = 12;
  localparam logic [2:0] PSC_DIV1     = 3'h0;
  localparam logic [2:0] PSC_DIV2     = 3'h1;
  localparam logic [2:0] PSC_DIV4     = 3'h3;
  localparam logic [2:0] PSC_DIV8     = 3'h7;

  localparam logic [15:0] CNT_MAX     = 16'hffff;
  localparam logic [7:0]  BYTE_MAX    = 8'hff;
  localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

  typedef enum logic [1:0] {
    SRC_HALT = 2'b00,
    SRC_OSC  = 2'b01,
    SRC_TEST = 2'b10,
    SRC_PIN  = 2'b11
  } src_e;

  typedef struct packed {
    logic [3:0]       div12;
    logic [2:0]       psc;
    logic [3:0]       cfg_prev;
    logic [15:0]      cnt;
    logic             cnt_new;
    logic [7:0]       ctl;
    logic [7:0]       edge_sel;
    logic [7:0]       flags;
    logic [5:0]       ste_lo;
    logic [1:0]       tgl;
    logic [7:0]       port_reset_toggle_enable;
    logic [3:0][15:0] cap;
    logic [2:0][15:0] cmp;
    logic [7:0]       port;
    logic [2:0]       cnt_sync;
    logic [2:0]       clr_sync;
    logic [3:0][2:0]  cap_sync;
    logic             wr_pend;
    logic [10:0]      idx;
    logic [31:0]      rdata;
    logic             ready;
    logic             irq;
  } state_s;

endpackage : cct_pkg
`default_nettype wire

// ---- tb/timer_pins.sv ----
/*
  model of the timer's external pins: count clock, counter clear and captures.
  assumes the bench calls its tasks; every pin changes just after hclk rises.
*/
`default_nettype none
module timer_pins (
  input  wire logic  hclk,
  output logic       count_pin,
  output logic       clear_pin,
  output logic [3:0] cap_pins
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    count_pin = 1'b0;
    clear_pin = 1'b0;
    cap_pins  = 4'h0;
  end

  // twelve cycles high and thirteen low keep the count rate at oscillator/25
  task automatic count_pulses(input int n);
    repeat (n) begin
      @(posedge hclk) count_pin <= 1'b1;
      repeat (12) @(posedge hclk);
      count_pin <= 1'b0;
      repeat (12) @(posedge hclk);
    end
  endtask : count_pulses

  task automatic clear_pulse;
    @(posedge hclk) clear_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    clear_pin <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask : clear_pulse

  task automatic set_caps(input logic [3:0] v);
    @(posedge hclk) cap_pins <= v;
    repeat (6) @(posedge hclk);
  endtask : set_caps
endmodule : timer_pins
`default_nettype wire

// ---- tb/capture_compare_timer_tb.sv ----
/*
  self-checking bench of the capture/compare timer over its ahb-lite port.
  assumes timer_pins drives the external pins and hclk is the oscillator.
*/
`default_nettype none
module capture_compare_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        hclk, hresetn, hsel, hwrite, idle_mode;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, rd;
  logic [7:0]  a;
  logic [15:0] cnt16;
  wire logic   hreadyout, hresp, overflow_irq, count_pin, clear_pin;
  wire logic [31:0] hrdata;
  wire logic [7:0]  port;
  wire logic [3:0]  cap_pins;
  int          error_cnt, tests_run, cycles;

  capture_compare_timer dut (
    .hclk (hclk), .hresetn (hresetn), .hsel (hsel), .haddr (haddr),
    .htrans (htrans), .hwrite (hwrite), .hsize (3'b010), .hwdata (hwdata),
    .hready (hreadyout), .hreadyout (hreadyout), .hresp (hresp),
    .hrdata (hrdata), .ext_count_pin (count_pin),
    .ext_counter_clear_pin (clear_pin), .capture_input_0 (cap_pins[0]),
    .capture_input_1 (cap_pins[1]), .capture_input_2 (cap_pins[2]),
    .capture_input_3 (cap_pins[3]), .idle_mode (idle_mode),
    .compare_output_port (port), .overflow_irq (overflow_irq)
  );
  timer_pins pins (.hclk (hclk), .count_pin (count_pin), .clear_pin (clear_pin),
    .cap_pins (cap_pins));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 12000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [10:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {19'h0_0000, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [10:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd);
  endtask : wr

  task automatic rdc(input logic [10:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0000_0000);
    check(rd, exp);
    check(32'(hresp), 32'h0000_0000);
  endtask : rdc

  // high, low, high again; a changed high byte means a carry fell between the reads
  task automatic rd_cnt(output logic [15:0] v);
    logic [7:0] hi;
    bus(1'b0, cct_pkg::IDX_CNT_HI, 32'h0000_0000);
    hi = rd[7:0];
    bus(1'b0, cct_pkg::IDX_CNT_LO, 32'h0000_0000);
    v = {hi, rd[7:0]};
    bus(1'b0, cct_pkg::IDX_CNT_HI, 32'h0000_0000);
    if (rd[7:0] != hi) begin
      hi = rd[7:0];
      bus(1'b0, cct_pkg::IDX_CNT_LO, 32'h0000_0000);
      v = {hi, rd[7:0]};
    end
  endtask : rd_cnt

  task automatic t_reset;
    for (int i = 0; i < 3; i++)
      rdc(cct_pkg::IDX_CMP0 + 11'(i), 32'h0000_0000);
    rdc(cct_pkg::IDX_FLAGS, 32'h0000_0000);
    rdc(cct_pkg::IDX_CNT_LO, 32'h0000_0000);
  endtask : t_reset

  task automatic t_prescale;
    for (int p = 0; p < 5; p++) begin
      wr(cct_pkg::IDX_CTRL, (p < 4) ? 32'(p * 4 + 1) : 32'h0000_0000);
      repeat (4) @(posedge hclk);
      bus(1'b0, cct_pkg::IDX_CNT_LO, 32'h0000_0000);
      a = rd[7:0];
      repeat (36 * (1 << (p % 4)) - 3) @(posedge hclk);
      bus(1'b0, cct_pkg::IDX_CNT_LO, 32'h0000_0000);
      check(32'(8'(rd[7:0] - a)), (p < 4) ? 32'h0000_0003 : 32'h0000_0000);
    end
  endtask : t_prescale

  task automatic t_compare;
    wr(cct_pkg::IDX_CTRL, 32'h0000_0020);
    pins.clear_pulse();
    rdc(cct_pkg::IDX_CNT_LO, 32'h0000_0000);
    for (int i = 0; i < 3; i++)
      wr(cct_pkg::IDX_CMP0 + 11'(i), 32'(16 * i + 16));
    wr(cct_pkg::IDX_STE, 32'h0000_00ff);
    rdc(cct_pkg::IDX_STE, 32'h0000_003f);
    wr(cct_pkg::IDX_RTE, 32'h0000_00c5);
    wr(cct_pkg::IDX_PORT, 32'h0000_0000);
    wr(cct_pkg::IDX_FLAGS, 32'h0000_0000);
    wr(cct_pkg::IDX_CTRL, 32'h0000_0021);
    repeat (700) @(posedge hclk);
    @(negedge hclk);
    check(32'(port), 32'h0000_00fa);
    rdc(cct_pkg::IDX_STE, 32'h0000_00ff);
    rdc(cct_pkg::IDX_FLAGS, 32'h0000_0070);
    wr(cct_pkg::IDX_CTRL, 32'h0000_0020);
    for (int i = 0; i < 3; i++)
      wr(cct_pkg::IDX_CMP0 + 11'(i), 32'h0000_0050);
    wr(cct_pkg::IDX_RTE, 32'h0000_00ff);
    wr(cct_pkg::IDX_PORT, 32'h0000_00ff);
    rdc(cct_pkg::IDX_PORT, 32'h0000_00ff);
    wr(cct_pkg::IDX_CTRL, 32'h0000_0021);
    repeat (400) @(posedge hclk);
    @(negedge hclk);
    check(32'(port), 32'h0000_0000);
    rdc(cct_pkg::IDX_STE, 32'h0000_003f);
  endtask : t_compare

  task automatic t_overflow;
    wr(cct_pkg::IDX_CTRL, 32'h0000_0061);
    @(negedge hclk);
    check(32'(overflow_irq), 32'h0000_0000);
    repeat (3100) @(posedge hclk);
    rdc(cct_pkg::IDX_CTRL, 32'h0000_0071);
    @(negedge hclk);
    check(32'(overflow_irq), 32'h0000_0001);
    wr(cct_pkg::IDX_CTRL, 32'h0000_0021);
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    check(32'(overflow_irq), 32'h0000_0000);
  endtask : t_overflow

  task automatic t_idle;
    @(posedge hclk) idle_mode <= 1'b1;
    repeat (30) @(posedge hclk);
    rdc(cct_pkg::IDX_CNT_LO, 32'h0000_0000);
    rdc(cct_pkg::IDX_CNT_HI, 32'h0000_0000);
    idle_mode <= 1'b0;
  endtask : t_idle

  task automatic t_ext_count;
    wr(cct_pkg::IDX_CTRL, 32'h0000_0020);
    pins.clear_pulse();
    wr(cct_pkg::IDX_CTRL, 32'h0000_0023);
    repeat (4) @(posedge hclk);
    pins.count_pulses(5);
    repeat (8) @(posedge hclk);
    wr(cct_pkg::IDX_CTRL, 32'h0000_0020);
    wr(cct_pkg::IDX_CNT_LO, 32'h0000_0077);
    rdc(cct_pkg::IDX_CNT_LO, 32'h0000_0005);
    rd_cnt(cnt16);
    check(32'(cnt16), 32'h0000_0005);
    wr(cct_pkg::IDX_CTRL, 32'h0000_0000);
    pins.clear_pulse();
    rdc(cct_pkg::IDX_CNT_LO, 32'h0000_0005);
  endtask : t_ext_count

  task automatic t_capture;
    wr(cct_pkg::IDX_EDGE, 32'h0000_0039);
    wr(cct_pkg::IDX_FLAGS, 32'h0000_0000);
    pins.set_caps(4'hf);
    rdc(cct_pkg::IDX_FLAGS, 32'h0000_0005);
    pins.set_caps(4'h0);
    rdc(cct_pkg::IDX_FLAGS, 32'h0000_0007);
    for (int i = 0; i < 4; i++)
      rdc(cct_pkg::IDX_CAP0 + 11'(i), (i < 3) ? 32'h0000_0005 : 32'h0000_0000);
    wr(cct_pkg::IDX_FLAGS, 32'h0000_0000);
    rdc(cct_pkg::IDX_FLAGS, 32'h0000_0000);
  endtask : t_capture

  initial begin
    hresetn   = 1'b0;
    hsel      = 1'b0;
    hwrite    = 1'b0;
    htrans    = 2'b00;
    haddr     = 32'h0000_0000;
    hwdata    = 32'h0000_0000;
    idle_mode = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_prescale();
    t_compare();
    t_overflow();
    t_idle();
    t_ext_count();
    t_capture();
    close_out();
  end
endmodule : capture_compare_timer_tb
`default_nettype wire
